// ==== rtl/async_serial_port_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module async_serial_port_ctrl
   import serial_port_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // special-function register port
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata_reg,
   // baud timer shared with the timer block
   input  wire logic       timer_tick,
   input  wire logic       timer_run,
   input  wire logic [7:0] baud_timer_reload,
   // interrupt
   input  wire logic       port_int_enable,
   output logic            irq_reg,
   // serial lines
   input  wire logic       rx_line,
   output logic            tx_line_reg
);
   // control fields
   logic       frame_width_select_reg, frame_width_select_next;
   logic       address_filter_enable_reg, address_filter_enable_next;
   logic       receiver_enable_reg, receiver_enable_next;
   logic       ninth_tx_bit_reg, ninth_tx_bit_next;
   logic       ninth_rx_bit_reg, ninth_rx_bit_next;
   logic       tx_done_flag_reg, tx_done_flag_next;
   logic       rx_done_flag_reg, rx_done_flag_next;
   logic [7:0] rx_latch_reg, rx_latch_next;
   logic [7:0] sfr_rdata_next, ctrl_view;
   logic       irq_next, ctrl_wr, data_wr;
   // transmitter
   tx_state_t  tx_state_reg, tx_state_next;
   logic [7:0] tx_hold_reg, tx_hold_next;
   logic       tx_pending_reg, tx_pending_next;
   logic [7:0] tx_shift_reg, tx_shift_next;
   logic       tx_ninth_reg, tx_ninth_next;
   logic [2:0] tx_cnt_reg, tx_cnt_next;
   logic       tx_line_next, tx_tick, tx_done_set;
   // receiver
   rx_state_t  rx_state_reg, rx_state_next;
   logic [7:0] rx_shift_reg, rx_shift_next;
   logic       rx_ninth_reg, rx_ninth_next;
   logic [2:0] rx_cnt_reg, rx_cnt_next;
   logic       rx_prev_reg, rx_tick, start_seen, rx_load, rx_check_bit;

   assign ctrl_wr = sfr_wr && (sfr_addr == CTRL_ADDR);
   assign data_wr = sfr_wr && (sfr_addr == DATA_ADDR);
   assign start_seen = (rx_state_reg == RX_IDLE) && receiver_enable_reg && rx_prev_reg && !rx_line;
   baud_half_timer #(.WIDTH(8)) u_tx_timer (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .timer_tick   (timer_tick),
      .timer_run    (timer_run),
      .reload_value (baud_timer_reload),
      .force_reload (1'b0),
      .bit_tick     (tx_tick)
   );
   // receive timer is a private copy, restarted on each start edge
   baud_half_timer #(.WIDTH(8)) u_rx_timer (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .timer_tick   (timer_tick),
      .timer_run    (timer_run),
      .reload_value (baud_timer_reload),
      .force_reload (start_seen),
      .bit_tick     (rx_tick)
   );
   // transmitter
   always_comb begin
      tx_state_next   = tx_state_reg;
      tx_hold_next    = tx_hold_reg;
      tx_pending_next = tx_pending_reg;
      tx_shift_next   = tx_shift_reg;
      tx_ninth_next   = tx_ninth_reg;
      tx_cnt_next     = tx_cnt_reg;
      tx_done_set     = 1'b0;
      if (data_wr) begin
         tx_hold_next    = sfr_wdata;
         tx_pending_next = 1'b1;
      end
      if (tx_tick) begin
         unique case (tx_state_reg)
            TX_IDLE: if (tx_pending_reg) begin
               tx_state_next   = TX_START;
               tx_shift_next   = tx_hold_reg;
               tx_ninth_next   = ninth_tx_bit_reg;
               tx_pending_next = data_wr;
            end
            TX_START: begin
               tx_state_next = TX_DATA;
               tx_cnt_next   = 3'h0;
            end
            TX_DATA: begin
               tx_shift_next = {1'b0, tx_shift_reg[7:1]};
               tx_cnt_next   = tx_cnt_reg + 3'h1;
               if (tx_cnt_reg == LAST_DATA_BIT) begin
                  if (frame_width_select_reg) begin
                     tx_state_next = TX_NINTH;
                  end else begin
                     tx_state_next = TX_STOP;
                     tx_done_set   = 1'b1;
                  end
               end
            end
            TX_NINTH: begin
               tx_state_next = TX_STOP;
               tx_done_set   = 1'b1;
            end
            TX_STOP: tx_state_next = TX_IDLE;
            default: tx_state_next = TX_IDLE;
         endcase
      end
      unique case (tx_state_next)
         TX_START: tx_line_next = 1'b0;
         TX_DATA:  tx_line_next = tx_shift_next[0];
         TX_NINTH: tx_line_next = tx_ninth_next;
         default:  tx_line_next = 1'b1;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tx_state_reg   <= TX_IDLE;
         tx_hold_reg    <= DATA_RESET;
         tx_pending_reg <= 1'b0;
         tx_shift_reg   <= DATA_RESET;
         tx_ninth_reg   <= 1'b0;
         tx_cnt_reg     <= 3'h0;
         tx_line_reg    <= 1'b1;
      end else begin
         tx_state_reg   <= tx_state_next;
         tx_hold_reg    <= tx_hold_next;
         tx_pending_reg <= tx_pending_next;
         tx_shift_reg   <= tx_shift_next;
         tx_ninth_reg   <= tx_ninth_next;
         tx_cnt_reg     <= tx_cnt_next;
         tx_line_reg    <= tx_line_next;
      end
   end

   // receiver
   always_comb begin
      rx_state_next = rx_state_reg;
      rx_shift_next = rx_shift_reg;
      rx_ninth_next = rx_ninth_reg;
      rx_cnt_next   = rx_cnt_reg;
      rx_load       = 1'b0;
      // stop bit in 8-bit, ninth bit in 9-bit
      rx_check_bit  = frame_width_select_reg ? rx_ninth_reg : rx_line;
      unique case (rx_state_reg)
         RX_IDLE: if (start_seen) rx_state_next = RX_START;
         RX_START: if (rx_tick) begin
            // a start that is high at mid-bit was a glitch
            rx_state_next = rx_line ? RX_IDLE : RX_DATA;
            rx_cnt_next   = 3'h0;
         end
         RX_DATA: if (rx_tick) begin
            rx_shift_next = {rx_line, rx_shift_reg[7:1]};
            rx_cnt_next   = rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == LAST_DATA_BIT) begin
               rx_state_next = frame_width_select_reg ? RX_NINTH : RX_STOP;
            end
         end
         RX_NINTH: if (rx_tick) begin
            rx_ninth_next = rx_line;
            rx_state_next = RX_STOP;
         end
         RX_STOP: if (rx_tick) begin
            rx_state_next = RX_IDLE;
            rx_load = !rx_done_flag_reg && (!address_filter_enable_reg || rx_check_bit);
         end
         default: rx_state_next = RX_IDLE;
      endcase
      // disabling aborts any frame in progress
      if (!receiver_enable_reg) begin
         rx_state_next = RX_IDLE;
         rx_load       = 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rx_state_reg <= RX_IDLE;
         rx_shift_reg <= DATA_RESET;
         rx_ninth_reg <= 1'b0;
         rx_cnt_reg   <= 3'h0;
         rx_prev_reg  <= 1'b1;
      end else begin
         rx_state_reg <= rx_state_next;
         rx_shift_reg <= rx_shift_next;
         rx_ninth_reg <= rx_ninth_next;
         rx_cnt_reg   <= rx_cnt_next;
         rx_prev_reg  <= rx_line;
      end
   end

   // control and data registers
   always_comb begin
      frame_width_select_next    = frame_width_select_reg;
      address_filter_enable_next = address_filter_enable_reg;
      receiver_enable_next       = receiver_enable_reg;
      ninth_tx_bit_next          = ninth_tx_bit_reg;
      ninth_rx_bit_next          = ninth_rx_bit_reg;
      tx_done_flag_next          = tx_done_flag_reg;
      rx_done_flag_next          = rx_done_flag_reg;
      rx_latch_next              = rx_latch_reg;
      if (ctrl_wr) begin
         frame_width_select_next    = sfr_wdata[FRAME_BIT];
         address_filter_enable_next = sfr_wdata[FILTER_BIT];
         receiver_enable_next       = sfr_wdata[RX_EN_BIT];
         ninth_tx_bit_next          = sfr_wdata[TX9_BIT];
         ninth_rx_bit_next          = sfr_wdata[RX9_BIT];
         tx_done_flag_next          = sfr_wdata[TX_DONE_BIT];
         rx_done_flag_next          = sfr_wdata[RX_DONE_BIT];
      end
      // hardware only sets; set beats a same-cycle clear
      if (tx_done_set) begin
         tx_done_flag_next = 1'b1;
      end
      if (rx_load) begin
         rx_done_flag_next = 1'b1;
         rx_latch_next     = rx_shift_reg;
         ninth_rx_bit_next = rx_check_bit;
      end
      ctrl_view = {frame_width_select_reg, 1'b1, address_filter_enable_reg, receiver_enable_reg,
                   ninth_tx_bit_reg, ninth_rx_bit_reg, tx_done_flag_reg, rx_done_flag_reg};
      // data reads return the receive latch
      if (sfr_addr == CTRL_ADDR) begin
         sfr_rdata_next = ctrl_view;
      end else if (sfr_addr == DATA_ADDR) begin
         sfr_rdata_next = rx_latch_reg;
      end else begin
         sfr_rdata_next = 8'h00;
      end
      irq_next = port_int_enable && (tx_done_flag_reg || rx_done_flag_reg);
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         frame_width_select_reg    <= CTRL_RESET[FRAME_BIT];
         address_filter_enable_reg <= CTRL_RESET[FILTER_BIT];
         receiver_enable_reg       <= CTRL_RESET[RX_EN_BIT];
         ninth_tx_bit_reg          <= CTRL_RESET[TX9_BIT];
         ninth_rx_bit_reg          <= CTRL_RESET[RX9_BIT];
         tx_done_flag_reg          <= CTRL_RESET[TX_DONE_BIT];
         rx_done_flag_reg          <= CTRL_RESET[RX_DONE_BIT];
         rx_latch_reg              <= DATA_RESET;
         sfr_rdata_reg             <= 8'h00;
         irq_reg                   <= 1'b0;
      end else begin
         frame_width_select_reg    <= frame_width_select_next;
         address_filter_enable_reg <= address_filter_enable_next;
         receiver_enable_reg       <= receiver_enable_next;
         ninth_tx_bit_reg          <= ninth_tx_bit_next;
         ninth_rx_bit_reg          <= ninth_rx_bit_next;
         tx_done_flag_reg          <= tx_done_flag_next;
         rx_done_flag_reg          <= rx_done_flag_next;
         rx_latch_reg              <= rx_latch_next;
         sfr_rdata_reg             <= sfr_rdata_next;
         irq_reg                   <= irq_next;
      end
   end
   chk_bit6_reads_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sfr_addr == CTRL_ADDR |=> sfr_rdata_reg[UNUSED_BIT]) else $error("control bit 6 read as zero");
   chk_rx_gate_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !receiver_enable_reg && !ctrl_wr |=> rx_state_reg == RX_IDLE && !rx_load) else $error("rx active while off");
   chk_tx_flag_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
      tx_done_flag_reg && !ctrl_wr |=> tx_done_flag_reg) else $error("tx done cleared by hardware");
   chk_rx_flag_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_done_flag_reg && !ctrl_wr |=> rx_done_flag_reg) else $error("rx done cleared by hardware");
   chk_latch_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_done_flag_reg |=> $stable(rx_latch_reg)) else $error("latch overwritten while flag set");
   chk_data_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sfr_addr == DATA_ADDR |=> sfr_rdata_reg == $past(rx_latch_reg)) else $error("data read not latch");
   chk_irq_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
      port_int_enable && (tx_done_flag_reg || rx_done_flag_reg) |=> irq_reg) else $error("irq missing");
   chk_start_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      tx_state_reg == TX_START |-> !tx_line_reg) else $error("start bit not low");
   chk_ninth_sent: assert property (@(posedge ref_clk) disable iff (!rst_n)
      tx_state_reg == TX_NINTH |-> tx_line_reg == tx_ninth_reg) else $error("ninth bit wrong");
   chk_tx_done_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(tx_done_flag_reg) && !$past(ctrl_wr) |-> tx_state_reg == TX_STOP && tx_line_reg)
      else $error("tx done not at stop");
endmodule // async_serial_port_ctrl
`default_nettype wire

// ==== rtl/serial_port_pkg.sv ====
// Functional notes
// - control bit 7 selects 8-bit framing when clear, 9-bit framing when set.
// - control bit 6 is unused; it reads as one and ignores writes.
// - 8-bit framing with filter set accepts a frame only when its stop bit is one.
// - 9-bit framing with filter set accepts a frame only when its ninth bit is one.
// - receiver enable bit 4 gates reception; clear means no frame is taken.
// - 9-bit framing sends control bit 3 as ninth bit; 8-bit framing ignores it.
// - on load, bit 2 captures stop bit (8-bit) or ninth data bit (9-bit).
// - transmit-done sets at the start of the stop bit in both framings.
// - hardware never clears the done flags; software clears them by writing zero.
// - receive-done sets when the stop bit of an accepted frame is sampled.
// - with the port interrupt enabled, either done flag raises the interrupt request.
// - writing the data buffer loads the transmit holding register; sending starts once the transmitter is idle.
// - reading the data buffer returns the receive latch, never transmit data.
// - transmit and receive bit clocks are the baud timer overflow rate halved.
// - a start condition on the receive line forces the receive timer to reload.
// - 8-bit frame: start bit, eight data bits LSB first, one stop bit.
// - a frame loads latch, ninth bit and flag only if flag clear and filter met.
package serial_port_pkg;
   localparam logic [7:0] CTRL_ADDR       = 8'h98;
   localparam logic [7:0] DATA_ADDR       = 8'h99;
   localparam logic [7:0] CTRL_RESET      = 8'h40;
   localparam logic [7:0] DATA_RESET      = 8'h00;
   localparam int         FRAME_BIT       = 7;
   localparam int         UNUSED_BIT      = 6;
   localparam int         FILTER_BIT      = 5;
   localparam int         RX_EN_BIT       = 4;
   localparam int         TX9_BIT         = 3;
   localparam int         RX9_BIT         = 2;
   localparam int         TX_DONE_BIT     = 1;
   localparam int         RX_DONE_BIT     = 0;
   localparam logic [2:0] LAST_DATA_BIT   = 3'h7;

   typedef enum logic [2:0] {
      TX_IDLE  = 3'b000,
      TX_START = 3'b001,
      TX_DATA  = 3'b010,
      TX_NINTH = 3'b011,
      TX_STOP  = 3'b100
   } tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_NINTH = 3'b011,
      RX_STOP  = 3'b100
   } rx_state_t;
endpackage

// ==== rtl/baud_half_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module baud_half_timer #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // timer clocking
   input  wire logic             timer_tick,
   input  wire logic             timer_run,
   input  wire logic [WIDTH-1:0] reload_value,
   input  wire logic             force_reload,
   // half-rate bit tick
   output logic                  bit_tick
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   logic             phase_reg;
   logic             phase_next;
   logic             overflow;

   always_comb begin
      overflow   = timer_run && timer_tick && (count_reg == {WIDTH{1'b1}});
      count_next = count_reg;
      phase_next = phase_reg;
      bit_tick   = overflow && !phase_reg;
      if (force_reload) begin
         count_next = reload_value;
         phase_next = 1'b0;
      end else if (overflow) begin
         count_next = reload_value;
         phase_next = !phase_reg;
      end else if (timer_run && timer_tick) begin
         count_next = count_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count_reg <= '0;
         phase_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         phase_reg <= phase_next;
      end
   end
endmodule // baud_half_timer
`default_nettype wire

// ==== dv/serial_peer.sv ====
`timescale 1ns/100ps
`default_nettype none
module serial_peer #(
   parameter int BIT_CYC = 8
) (
   // clock
   input  wire logic       ref_clk,
   // serial lines
   input  wire logic       tx_line,
   output logic            rx_line,
   // framing and report
   input  wire logic       nine_mode,
   output logic            got_valid,
   output logic      [9:0] got_word
);
   logic [9:0] shift_reg;

   initial begin
      rx_line   = 1'b1;
      got_valid = 1'b0;
      got_word  = 10'h000;
      shift_reg = 10'h000;
   end

   task automatic send_frame(input logic [7:0] data, input logic ninth, input logic stop_bit);
      logic [10:0] bits;
      int          n;
      n    = nine_mode ? 11 : 10;
      bits = nine_mode ? {stop_bit, ninth, data, 1'b0} : {1'b1, stop_bit, data, 1'b0};
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         #1 rx_line = bits[i];
         repeat (BIT_CYC - 1) @(posedge ref_clk);
      end
      // idle level is high, so a low stop bit is released here
      @(posedge ref_clk);
      #1 rx_line = 1'b1;
   endtask

   initial begin
      forever begin
         @(negedge ref_clk);
         if (tx_line === 1'b0) begin
            repeat (BIT_CYC / 2) @(negedge ref_clk);
            for (int i = 0; i < 10; i++) begin
               if (i < 9 || nine_mode) begin
                  repeat (BIT_CYC) @(negedge ref_clk);
                  shift_reg[i] = tx_line;
               end
            end
            got_word  = nine_mode ? shift_reg : {shift_reg[8], 1'b0, shift_reg[7:0]};
            got_valid = 1'b1;
            @(negedge ref_clk);
            got_valid = 1'b0;
         end
      end
   end
endmodule // serial_peer
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
   import serial_port_pkg::*;
   localparam logic [7:0] RELOAD  = 8'hFC;
   localparam int         BIT_CYC = 2 * (256 - 252);

   logic       ref_clk = 1'b0;
   logic       rst_n, sfr_wr, port_int_enable, rx_line, tx_line_reg, irq_reg;
   logic       nine_mode, got_valid, rd_chk;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_reg;
   logic [9:0] got_word;
   logic [8:0] rd_q[$];
   logic [9:0] frm_q[$];
   logic [6:0] rx_tab [9] = '{7'h13, 7'h15, 7'h30, 7'h33, 7'h53, 7'h72, 7'h77, 7'h02, 7'h1A};
   int         error_cnt = 0;
   int         total_checks = 0;

   always #50 ref_clk = ~ref_clk;

   async_serial_port_ctrl dut_u (
      .ref_clk           (ref_clk),
      .rst_n             (rst_n),
      .sfr_addr          (sfr_addr),
      .sfr_wr            (sfr_wr),
      .sfr_wdata         (sfr_wdata),
      .sfr_rdata_reg     (sfr_rdata_reg),
      .timer_tick        (1'b1),
      .timer_run         (1'b1),
      .baud_timer_reload (RELOAD),
      .port_int_enable   (port_int_enable),
      .irq_reg           (irq_reg),
      .rx_line           (rx_line),
      .tx_line_reg       (tx_line_reg)
   );

   serial_peer #(.BIT_CYC(BIT_CYC)) peer_u (
      .ref_clk   (ref_clk),
      .tx_line   (tx_line_reg),
      .rx_line   (rx_line),
      .nine_mode (nine_mode),
      .got_valid (got_valid),
      .got_word  (got_word)
   );

   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      if (error_cnt == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1 sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge ref_clk);
      #1 sfr_wr = 1'b0;
   endtask

   // expected value is {irq, read data}
   task automatic rd(input logic [7:0] a, input logic [8:0] e);
      @(posedge ref_clk);
      #1 sfr_addr = a;
      rd_q.push_back(e);
      @(posedge ref_clk);
      #1 rd_chk = 1'b1;
      @(negedge ref_clk);
      #1 rd_chk = 1'b0;
   endtask

   task automatic drain;
      int n;
      n = 0;
      while (frm_q.size() != 0 && n < 4000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 4000)
         error_cnt++;
      repeat (4) @(posedge ref_clk);
   endtask

   always @(negedge ref_clk)
      if (rd_chk) check({1'b0, irq_reg, sfr_rdata_reg}, {1'b0, rd_q.pop_front()});
   always @(posedge got_valid)
      check(got_word, frm_q.pop_front());

   initial begin
      repeat (30000) @(posedge ref_clk);
      error_cnt++;
      give_verdict();
   end

   initial begin
      logic [7:0] d, c, last_d;
      logic [6:0] t;
      logic       en, rb;
      rst_n = 1'b0;
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_wdata = 8'h00;
      port_int_enable = 1'b1;
      nine_mode = 1'b0;
      rd_chk = 1'b0;
      void'($urandom(66));
      repeat (20) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      rd(CTRL_ADDR, {1'b0, CTRL_RESET});
      rd(DATA_ADDR, {1'b0, DATA_RESET});
      wr(8'h97, 8'hFF);
      rd(8'h97, 9'h000);
      rd(CTRL_ADDR, 9'h040);
      wr(CTRL_ADDR, 8'h0F);
      rd(CTRL_ADDR, 9'h14F);
      wr(CTRL_ADDR, 8'h00);
      rd(CTRL_ADDR, 9'h040);
      // both framings, ninth bit clear and set
      for (int k = 0; k < 4; k++) begin
         c = {k[1], 3'h0, k[0], 3'h0};
         nine_mode = k[1];
         wr(CTRL_ADDR, c);
         d = 8'($urandom);
         frm_q.push_back({1'b1, k[1] & k[0], d});
         wr(DATA_ADDR, d);
         repeat (4 * BIT_CYC) @(posedge ref_clk);
         rd(CTRL_ADDR, {1'b0, c | 8'h40});
         drain();
         rd(CTRL_ADDR, {1'b1, c | 8'h42});
      end
      repeat (100) @(posedge ref_clk);
      rd(CTRL_ADDR, 9'h1CA);
      nine_mode = 1'b0;
      wr(CTRL_ADDR, 8'h00);
      // second write lands while the first frame is on the wire
      for (int k = 0; k < 2; k++) begin
         d = 8'($urandom);
         frm_q.push_back({2'b10, d});
         wr(DATA_ADDR, d);
         repeat (2 * BIT_CYC) @(posedge ref_clk);
      end
      drain();
      rd(DATA_ADDR, 9'h100);
      last_d = 8'h00;
      rb = 1'b0;
      // table: mode, filter, enable, preset flag, ninth, stop, loaded
      foreach (rx_tab[i]) begin
         t = rx_tab[i];
         nine_mode = t[6];
         en = 1'($urandom);
         @(posedge ref_clk);
         #1 port_int_enable = en;
         c = {t[6], 1'b1, t[5], t[4], 1'b0, rb, 1'b0, t[3]};
         wr(CTRL_ADDR, c);
         d = 8'($urandom);
         repeat ($urandom % 8) @(posedge ref_clk);
         peer_u.send_frame(d, t[2], t[1]);
         repeat (BIT_CYC) @(posedge ref_clk);
         if (t[0]) begin
            last_d = d;
            rb = t[6] ? t[2] : t[1];
         end
         c = {c[7:3], rb, 1'b0, t[0] | t[3]};
         rd(CTRL_ADDR, {en & c[0], c});
         rd(DATA_ADDR, {en & c[0], last_d});
      end
      give_verdict();
   end
endmodule // tb
`default_nettype wire
